// file: logic/ckb_output_ctrl.sv
// serial configuration, power-down and output-stop control of the buffer
//
// Behaviour
// - two low samples, park on complement fall
// - drive mode 0: true high, complement tri-stated
// - drive mode 1: both outputs tri-stated
// - park outputs first, then stop PLL
// - locked clocks within one millisecond
// - tri-state mode: drive outputs high on release
// - stop request debounced over two edges
// - stoppable pairs halt on next true rising edge
// - stop mode 0: true high, complement undriven
// - stop mode 1: both outputs undriven
// - resume all together, two to six periods
// - tri-state stop: drive high on release
// - byte zero holds drive modes, polarity
// - byte zero holds bandwidth, bypass, rate
// - byte one enables each pair, reset ones
// - byte two marks pairs stoppable, reset zeros
// - byte count register resets to seven
// - read-only revision and vendor byte
// - device code in byte five
// - respond to addresses DC and DD
`timescale 1ns/1ps
`default_nettype none

module ckb_output_ctrl #(
	parameter int unsigned LOCK_CYCLES = ckb_pkg::LOCK_CYCLES,
	parameter int unsigned N_PAIRS = 8
) (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic clk_ref_in,
	input wire logic smb_clock_in,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe_n_out,
	input wire logic power_down_n_in,
	input wire logic output_halt_request_n_in,
	output logic [7:0] clock_output_true_out,
	output logic [7:0] clock_output_true_oe_n_out,
	output logic [7:0] clock_output_complement_out,
	output logic [7:0] clock_output_complement_oe_n_out,
	output logic reduced_drive_out,
	output logic pll_enable_out,
	output logic loop_bandwidth_select_out,
	output logic pll_mode_select_out
);

	if (N_PAIRS != 8 || LOCK_CYCLES < 1) begin : g_check
		$error("ckb_output_ctrl: unsupported parameter values");
	end

	// ********************************************************
	// serial line synchronisers and conditions
	// ********************************************************
	logic [2:0] scl_s_q, sda_s_q;
	logic scl_q, sda_q, scl_new, sda_new;
	logic scl_rise, scl_fall, smb_start, smb_stop;

	always_ff @(posedge clk_sys_in) begin
		scl_s_q <= {scl_s_q[1:0], smb_clock_in};
		sda_s_q <= {sda_s_q[1:0], smb_data_in};
		if (!reset_n_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_new;
			sda_q <= sda_new;
		end
	end

	always_comb begin
		scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
		sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
		scl_rise = scl_new && !scl_q;
		scl_fall = !scl_new && scl_q;
		smb_start = scl_q && scl_new && sda_q && !sda_new;
		smb_stop = scl_q && scl_new && !sda_q && sda_new;
	end

	// ********************************************************
	// configuration registers
	// ********************************************************
	logic [7:0] drive_pll_q, enable_q, stoppable_q, reserved_q;
	logic [7:0] device_q, byte_count_q;
	logic [7:0] shift_q, tx_q, ptr_q, wr_left_q, rd_left_q;
	logic [3:0] bit_cnt_q;
	logic rd_mode_q, wr_fire, byte_done;
	ckb_pkg::ckb_smb_st_e st_q;
	ckb_pkg::ckb_stage_e stage_q;

	function automatic logic [7:0] reg_read(input logic [7:0] idx);
		case (idx)
			ckb_pkg::REG_DRIVE_PLL: reg_read = drive_pll_q;
			ckb_pkg::REG_ENABLE: reg_read = enable_q;
			ckb_pkg::REG_STOPPABLE: reg_read = stoppable_q;
			ckb_pkg::REG_RESERVED: reg_read = reserved_q;
			ckb_pkg::REG_VENDOR_REV: reg_read = ckb_pkg::ID_VENDOR_REV;
			ckb_pkg::REG_DEVICE: reg_read = device_q;
			ckb_pkg::REG_BYTE_COUNT: reg_read = byte_count_q;
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	assign byte_done = st_q == ckb_pkg::SMB_RECV && scl_fall &&
		bit_cnt_q == ckb_pkg::SMB_BITS && !smb_start && !smb_stop;
	assign wr_fire = byte_done && stage_q == ckb_pkg::STG_DATA &&
		wr_left_q != 8'h00;

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			// drive modes and polarity reset to zero
			// bandwidth, bypass and rate reset to one
			drive_pll_q <= ckb_pkg::RST_DRIVE_PLL;
			enable_q <= ckb_pkg::RST_ENABLE;
			stoppable_q <= ckb_pkg::RST_STOPPABLE;
			reserved_q <= ckb_pkg::RST_RESERVED;
			device_q <= ckb_pkg::ID_DEVICE;
			byte_count_q <= ckb_pkg::RST_BYTE_COUNT;
		end else if (wr_fire) begin
			case (ptr_q)
				ckb_pkg::REG_DRIVE_PLL: drive_pll_q <= shift_q;
				ckb_pkg::REG_ENABLE: enable_q <= shift_q;
				ckb_pkg::REG_STOPPABLE: stoppable_q <= shift_q;
				ckb_pkg::REG_RESERVED: reserved_q <= shift_q;
				ckb_pkg::REG_DEVICE: device_q <= shift_q;
				ckb_pkg::REG_BYTE_COUNT: byte_count_q <= shift_q;
				default: ;
			endcase
		end
	end

	assign loop_bandwidth_select_out = drive_pll_q[ckb_pkg::BIT_LOOP_BW];
	assign pll_mode_select_out = drive_pll_q[ckb_pkg::BIT_PLL_MODE];

	// ********************************************************
	// serial slave
	// ********************************************************
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			st_q <= ckb_pkg::SMB_IDLE;
			stage_q <= ckb_pkg::STG_ADDR;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			wr_left_q <= 8'h00;
			rd_left_q <= 8'h00;
			rd_mode_q <= 1'b0;
		end else if (smb_start) begin
			st_q <= ckb_pkg::SMB_RECV;
			stage_q <= ckb_pkg::STG_ADDR;
			bit_cnt_q <= 4'h0;
			rd_mode_q <= 1'b0;
		end else if (smb_stop) begin
			st_q <= ckb_pkg::SMB_IDLE;
		end else begin
			case (st_q)
				ckb_pkg::SMB_RECV: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_new};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (byte_done) begin
						st_q <= ckb_pkg::SMB_RACK;
						case (stage_q)
							// own write and read addresses only
							ckb_pkg::STG_ADDR: begin
								if (shift_q == ckb_pkg::SMB_WR_ADDR) begin
									stage_q <= ckb_pkg::STG_INDEX;
								end else if (shift_q == ckb_pkg::SMB_RD_ADDR) begin
									rd_mode_q <= 1'b1;
									tx_q <= byte_count_q;
									rd_left_q <= byte_count_q;
								end else begin
									st_q <= ckb_pkg::SMB_IDLE;
								end
							end
							ckb_pkg::STG_INDEX: begin
								ptr_q <= shift_q;
								stage_q <= ckb_pkg::STG_COUNT;
							end
							ckb_pkg::STG_COUNT: begin
								wr_left_q <= shift_q;
								stage_q <= ckb_pkg::STG_DATA;
							end
							default: begin
								if (wr_left_q != 8'h00) begin
									ptr_q <= ptr_q + 8'h01;
									wr_left_q <= wr_left_q - 8'h01;
								end
							end
						endcase
					end
				end
				ckb_pkg::SMB_RACK: begin
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						st_q <= rd_mode_q ? ckb_pkg::SMB_SEND :
							ckb_pkg::SMB_RECV;
					end
				end
				ckb_pkg::SMB_SEND: begin
					if (scl_fall) begin
						if (bit_cnt_q == ckb_pkg::SMB_BITS - 4'h1) begin
							st_q <= ckb_pkg::SMB_SACK;
						end else begin
							bit_cnt_q <= bit_cnt_q + 4'h1;
							tx_q <= {tx_q[6:0], 1'b0};
						end
					end
				end
				ckb_pkg::SMB_SACK: begin
					// not-acknowledge from the host ends the read
					if (scl_rise) begin
						if (sda_new || rd_left_q == 8'h00) begin
							st_q <= ckb_pkg::SMB_IDLE;
						end else begin
							tx_q <= reg_read(ptr_q);
							ptr_q <= ptr_q + 8'h01;
							rd_left_q <= rd_left_q - 8'h01;
						end
					end else if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						st_q <= ckb_pkg::SMB_SEND;
					end
				end
				default: st_q <= ckb_pkg::SMB_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			smb_data_oe_n_out <= 1'b1;
		end else begin
			smb_data_oe_n_out <= !(st_q == ckb_pkg::SMB_RACK ||
				(st_q == ckb_pkg::SMB_SEND && !tx_q[7]));
		end
	end
	assign smb_data_out = 1'b0;

	// ********************************************************
	// configuration crossing and PLL lock timing
	// ********************************************************
	ckb_pkg::ckb_cfg_s cfg_live, shadow_q, cfg_q;
	logic req_q, ack_q;
	logic [1:0] ack_s_q, req_s_q, park_s_q, ready_s_q, rrst_q;
	logic pll_en_q, ready_q, park_q, ref_rst_n;
	logic [31:0] lock_cnt_q;

	always_comb begin
		cfg_live.sleep_drive_mode = drive_pll_q[ckb_pkg::BIT_SLEEP_MODE];
		cfg_live.stop_drive_mode = drive_pll_q[ckb_pkg::BIT_STOP_MODE];
		cfg_live.sleep_polarity = drive_pll_q[ckb_pkg::BIT_SLEEP_POL];
		cfg_live.half_rate_select = drive_pll_q[ckb_pkg::BIT_HALF_RATE];
		cfg_live.enable = enable_q;
		cfg_live.stoppable = stoppable_q;
	end

	always_ff @(posedge clk_sys_in) begin
		ack_s_q <= {ack_s_q[0], ack_q};
		park_s_q <= {park_s_q[0], park_q};
		if (!reset_n_in) begin
			shadow_q <= ckb_pkg::CFG_RESET;
			req_q <= 1'b0;
		end else if (ack_s_q[1] == req_q && shadow_q != cfg_live) begin
			shadow_q <= cfg_live;
			req_q <= !req_q;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			pll_en_q <= 1'b1;
			ready_q <= 1'b0;
			lock_cnt_q <= 32'h0;
		end else begin
			// PLL stops only once the outputs are parked
			pll_en_q <= !park_s_q[1];
			if (park_s_q[1]) begin
				ready_q <= 1'b0;
				lock_cnt_q <= 32'h0;
			// lock wait bounded below one millisecond
			end else if (lock_cnt_q == LOCK_CYCLES) begin
				ready_q <= 1'b1;
			end else begin
				lock_cnt_q <= lock_cnt_q + 32'h1;
			end
		end
	end
	assign pll_enable_out = pll_en_q;

	// ********************************************************
	// reference clock domain
	// ********************************************************
	logic [2:0] pd_s_q, stop_s_q;
	logic pd_lvl_q, pd_hist_q, pd_acc_q, stop_lvl_q, stop_hist_q;
	logic stop_acc_q, div_q, phase_q, tick, crise, cfall;
	logic pd_active, stop_active;
	logic [7:0] stopped_q;
	logic [2:0] resume_cnt_q;
	ckb_pkg::ckb_ref_st_e rst_q;

	always_ff @(posedge clk_ref_in) begin
		rrst_q <= {rrst_q[0], reset_n_in};
		req_s_q <= {req_s_q[0], req_q};
		ready_s_q <= {ready_s_q[0], ready_q};
		pd_s_q <= {pd_s_q[1:0], power_down_n_in};
		stop_s_q <= {stop_s_q[1:0], output_halt_request_n_in};
	end
	assign ref_rst_n = rrst_q[1];

	always_ff @(posedge clk_ref_in) begin
		if (!ref_rst_n) begin
			cfg_q <= ckb_pkg::CFG_RESET;
			ack_q <= 1'b0;
		end else if (req_s_q[1] != ack_q) begin
			cfg_q <= shadow_q;
			ack_q <= req_s_q[1];
		end
	end

	assign tick = cfg_q.half_rate_select || div_q;
	assign crise = tick && phase_q;
	assign cfall = tick && !phase_q;
	assign pd_active = cfg_q.sleep_polarity ? pd_acc_q : !pd_acc_q;
	assign stop_active = !stop_acc_q;

	always_ff @(posedge clk_ref_in) begin
		if (!ref_rst_n) begin
			div_q <= 1'b0;
			phase_q <= 1'b0;
		end else begin
			div_q <= !div_q;
			if (tick) begin
				phase_q <= !phase_q;
			end
		end
	end

	always_ff @(posedge clk_ref_in) begin
		if (!ref_rst_n) begin
			pd_lvl_q <= 1'b1;
			pd_hist_q <= 1'b1;
			pd_acc_q <= 1'b1;
			stop_lvl_q <= 1'b1;
			stop_hist_q <= 1'b1;
			stop_acc_q <= 1'b1;
		end else begin
			if (pd_s_q[1] == pd_s_q[2]) begin
				pd_lvl_q <= pd_s_q[2];
			end
			if (stop_s_q[1] == stop_s_q[2]) begin
				stop_lvl_q <= stop_s_q[2];
			end
			// accept on two complement rising edges
			// stop level must hold for two edges
			if (crise) begin
				pd_hist_q <= pd_lvl_q;
				stop_hist_q <= stop_lvl_q;
				if (pd_hist_q == pd_lvl_q) begin
					pd_acc_q <= pd_lvl_q;
				end
				if (stop_hist_q == stop_lvl_q) begin
					stop_acc_q <= stop_lvl_q;
				end
			end
		end
	end

	always_ff @(posedge clk_ref_in) begin
		if (!ref_rst_n) begin
			rst_q <= ckb_pkg::REF_RUN;
		end else begin
			case (rst_q)
				// park on the next complement fall
				ckb_pkg::REF_RUN: if (pd_active && cfall) begin
					rst_q <= ckb_pkg::REF_PARK;
				end
				ckb_pkg::REF_PARK: if (!pd_active && !ready_s_q[1]) begin
					rst_q <= ckb_pkg::REF_WAKE;
				end
				ckb_pkg::REF_WAKE: begin
					if (pd_active && cfall) begin
						rst_q <= ckb_pkg::REF_PARK;
					end else if (ready_s_q[1]) begin
						rst_q <= ckb_pkg::REF_RUN;
					end
				end
				default: rst_q <= ckb_pkg::REF_RUN;
			endcase
		end
	end
	assign park_q = rst_q == ckb_pkg::REF_PARK;

	always_ff @(posedge clk_ref_in) begin
		if (!ref_rst_n) begin
			stopped_q <= 8'h00;
			resume_cnt_q <= 3'h0;
		end else if (stop_active) begin
			resume_cnt_q <= 3'h0;
			// halt stoppable pairs after the rising true edge
			if (cfall && rst_q == ckb_pkg::REF_RUN) begin
				stopped_q <= stopped_q | cfg_q.stoppable;
			end
		end else if (stopped_q != 8'h00 && crise) begin
			// release every pair on the same edge
			if (resume_cnt_q == ckb_pkg::RESUME_PERIODS) begin
				stopped_q <= 8'h00;
				resume_cnt_q <= 3'h0;
			end else begin
				resume_cnt_q <= resume_cnt_q + 3'h1;
			end
		end
	end

	// ********************************************************
	// output pin drive
	// ********************************************************
	always_ff @(posedge clk_ref_in) begin
		if (!ref_rst_n) begin
			clock_output_true_out <= 8'h00;
			clock_output_true_oe_n_out <= 8'hFF;
			clock_output_complement_out <= 8'h00;
			clock_output_complement_oe_n_out <= 8'hFF;
			reduced_drive_out <= 1'b0;
		end else begin
			reduced_drive_out <= rst_q != ckb_pkg::REF_RUN;
			for (int i = 0; i < 8; i++) begin
				clock_output_true_out[i] <= 1'b0;
				clock_output_true_oe_n_out[i] <= 1'b1;
				clock_output_complement_out[i] <= 1'b0;
				clock_output_complement_oe_n_out[i] <= 1'b1;
				if (!cfg_q.enable[i]) begin
				// sleep mode 1 leaves both undriven
				// on release the true output is driven high
				end else if (rst_q != ckb_pkg::REF_RUN) begin
					if (rst_q == ckb_pkg::REF_WAKE || !cfg_q.sleep_drive_mode) begin
						clock_output_true_out[i] <= 1'b1;
						clock_output_true_oe_n_out[i] <= 1'b0;
					end
				// stop mode 0 drives only the true side
				// stop mode 1 leaves both undriven
				// raw release drives the true side at once
				end else if (stopped_q[i]) begin
					if (!cfg_q.stop_drive_mode || stop_lvl_q) begin
						clock_output_true_out[i] <= 1'b1;
						clock_output_true_oe_n_out[i] <= 1'b0;
					end
				end else begin
					clock_output_true_out[i] <= phase_q;
					clock_output_true_oe_n_out[i] <= 1'b0;
					clock_output_complement_out[i] <= !phase_q;
					clock_output_complement_oe_n_out[i] <= 1'b0;
				end
			end
		end
	end

	// ********************************************************
	// assertions
	// ********************************************************
	a_park_on_fall: assert property (@(posedge clk_ref_in)
		disable iff (!ref_rst_n)
		(rst_q == ckb_pkg::REF_RUN && pd_active && cfall) |=>
		rst_q == ckb_pkg::REF_PARK)
		else $error("park not entered on complement fall");

	a_park_driven_high: assert property (@(posedge clk_ref_in)
		disable iff (!ref_rst_n)
		(park_q && !cfg_q.sleep_drive_mode && $stable(cfg_q)) |=>
		(clock_output_true_out == cfg_q.enable &&
		clock_output_complement_oe_n_out == 8'hFF))
		else $error("driven park state wrong");

	a_park_tristate: assert property (@(posedge clk_ref_in)
		disable iff (!ref_rst_n)
		(park_q && cfg_q.sleep_drive_mode && $stable(cfg_q)) |=>
		(clock_output_true_oe_n_out == 8'hFF &&
		clock_output_complement_oe_n_out == 8'hFF))
		else $error("tri-state park drives a pin");

	a_pll_after_park: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		$fell(pll_en_q) |-> $past(park_s_q[1]))
		else $error("PLL stopped before outputs parked");

	a_lock_time: assert property (@(posedge clk_sys_in)
		disable iff (!reset_n_in)
		$rose(ready_q) |-> ($past(lock_cnt_q) == LOCK_CYCLES &&
		$past(pll_en_q)))
		else $error("ready without full lock wait");

	a_wake_drive: assert property (@(posedge clk_ref_in)
		disable iff (!ref_rst_n)
		(rst_q == ckb_pkg::REF_WAKE && $stable(cfg_q)) |=>
		(clock_output_true_oe_n_out == ~cfg_q.enable))
		else $error("outputs not driven after power-down release");

	a_stop_debounce: assert property (@(posedge clk_ref_in)
		disable iff (!ref_rst_n)
		$changed(stop_acc_q) |-> $past(crise && stop_hist_q == stop_lvl_q))
		else $error("stop accepted without two agreeing samples");

	a_stop_halt: assert property (@(posedge clk_ref_in)
		disable iff (!ref_rst_n)
		((stopped_q & ~$past(stopped_q)) != 8'h00) |->
		$past(cfall && stop_active))
		else $error("pair halted off its transition");

	a_resume_together: assert property (@(posedge clk_ref_in)
		disable iff (!ref_rst_n)
		$fell(stopped_q != 8'h00) |-> $past(crise && !stop_active))
		else $error("stopped pairs resumed out of step");

	a_cfg_reset: assert property (@(posedge clk_sys_in)
		$rose(reset_n_in) |-> (byte_count_q == ckb_pkg::RST_BYTE_COUNT &&
		drive_pll_q == ckb_pkg::RST_DRIVE_PLL && enable_q == 8'hFF))
		else $error("register reset value wrong");

endmodule : ckb_output_ctrl

`default_nettype wire

// file: logic/ckb_pkg.sv
// constants, types and state encodings for the clock buffer output control
package ckb_pkg;

	// ********************************************************
	// clocks and timing
	// ********************************************************
	localparam int CLK_MHZ = 100;
	// stable locked clocks in less than this many microseconds
	localparam int LOCK_TIME_US = 1000;
	// margin for the counter end and the crossings keeps ready under the limit
	localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ - 32;
	// one less than the output periods waited after an accepted stop release
	localparam logic [2:0] RESUME_PERIODS = 3'h2;

	// ********************************************************
	// serial interface
	// ********************************************************
	localparam logic [7:0] SMB_WR_ADDR = 8'hDC;
	localparam logic [7:0] SMB_RD_ADDR = 8'hDD;
	localparam logic [3:0] SMB_BITS = 4'h8;

	// ********************************************************
	// register indices and reset values
	// ********************************************************
	localparam logic [7:0] REG_DRIVE_PLL = 8'h00;
	localparam logic [7:0] REG_ENABLE = 8'h01;
	localparam logic [7:0] REG_STOPPABLE = 8'h02;
	localparam logic [7:0] REG_RESERVED = 8'h03;
	localparam logic [7:0] REG_VENDOR_REV = 8'h04;
	localparam logic [7:0] REG_DEVICE = 8'h05;
	localparam logic [7:0] REG_BYTE_COUNT = 8'h06;
	localparam logic [7:0] RST_DRIVE_PLL = 8'h07;
	localparam logic [7:0] RST_ENABLE = 8'hFF;
	localparam logic [7:0] RST_STOPPABLE = 8'h00;
	localparam logic [7:0] RST_RESERVED = 8'h00;
	localparam logic [7:0] RST_BYTE_COUNT = 8'h07;
	// identification values are arbitrary
	localparam logic [7:0] ID_VENDOR_REV = 8'hA5;
	localparam logic [7:0] ID_DEVICE = 8'h5A;

	// ********************************************************
	// field positions in drive_and_pll_config
	// ********************************************************
	localparam int BIT_SLEEP_MODE = 7;
	localparam int BIT_STOP_MODE = 6;
	localparam int BIT_SLEEP_POL = 5;
	localparam int BIT_LOOP_BW = 2;
	localparam int BIT_PLL_MODE = 1;
	localparam int BIT_HALF_RATE = 0;

	// ********************************************************
	// types
	// ********************************************************
	typedef struct packed {
		logic sleep_drive_mode;
		logic stop_drive_mode;
		logic sleep_polarity;
		logic half_rate_select;
		logic [7:0] enable;
		logic [7:0] stoppable;
	} ckb_cfg_s;

	localparam ckb_cfg_s CFG_RESET = '{
		sleep_drive_mode: RST_DRIVE_PLL[BIT_SLEEP_MODE],
		stop_drive_mode: RST_DRIVE_PLL[BIT_STOP_MODE],
		sleep_polarity: RST_DRIVE_PLL[BIT_SLEEP_POL],
		half_rate_select: RST_DRIVE_PLL[BIT_HALF_RATE],
		enable: RST_ENABLE,
		stoppable: RST_STOPPABLE
	};

	typedef enum logic [2:0] {
		SMB_IDLE, SMB_RECV, SMB_RACK, SMB_SEND, SMB_SACK
	} ckb_smb_st_e;

	typedef enum logic [1:0] {
		STG_ADDR, STG_INDEX, STG_COUNT, STG_DATA
	} ckb_stage_e;

	typedef enum logic [1:0] {
		REF_RUN, REF_PARK, REF_WAKE
	} ckb_ref_st_e;

endpackage : ckb_pkg

// file: tb/ckb_host_model.sv
// serial host model for the configuration pins
`timescale 1ns/1ps
`default_nettype none
module ckb_host_model (
	input wire logic clk_in,
	input wire logic dev_oe_n_in,
	output logic scl_out,
	output logic sda_out
);
	logic drv_q;
	logic [7:0] buf_q [0:7];
	// open-drain line with pull-up
	assign sda_out = drv_q & dev_oe_n_in;
	initial begin
		scl_out = 1'b1;
		drv_q = 1'b1;
	end
	task automatic hp;
		repeat (10) @(negedge clk_in);
	endtask : hp
	task automatic cond(input logic a, input logic b);
		drv_q = a;
		hp();
		scl_out = 1'b1;
		hp();
		drv_q = b;
		hp();
	endtask : cond
	task automatic start;
		cond(1'b1, 1'b0);
		scl_out = 1'b0;
		hp();
	endtask : start
	task automatic bit_io(input logic b, output logic r);
		drv_q = b;
		hp();
		scl_out = 1'b1;
		hp();
		r = sda_out;
		scl_out = 1'b0;
		hp();
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(last, ack);
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] idx,
		input logic [7:0] d, output logic ack);
		logic [7:0] r;
		logic k;
		start();
		xfer(a, 1'b1, r, ack);
		xfer(idx, 1'b1, r, k);
		xfer(8'h01, 1'b1, r, k);
		xfer(d, 1'b1, r, k);
		cond(1'b0, 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input int n,
		output logic [7:0] cnt);
		logic [7:0] r;
		logic k;
		start();
		xfer(8'hDC, 1'b1, r, k);
		xfer(idx, 1'b1, r, k);
		start();
		xfer(8'hDD, 1'b1, r, k);
		xfer(8'hFF, 1'b0, cnt, k);
		for (int i = 0; i < n; i++) begin
			xfer(8'hFF, i == n - 1, buf_q[i], k);
		end
		cond(1'b0, 1'b1);
	endtask : rd
endmodule : ckb_host_model
`default_nettype wire

// file: tb/clock_buffer_output_control_bench.sv
// self-checking bench of the buffer output control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("mismatch %s exp %h got %h", nm, e, g); \
	end \
end
module clock_buffer_output_control_bench;
	logic clk_sys_in = 1'b0;
	logic clk_ref_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic pd_n = 1'b1;
	logic halt_n = 1'b1;
	logic scl, sda, sdo, oe_n, rdd, pll_en, bw, pm, k;
	logic [7:0] t, c, t_oe_n, c_oe_n, s, cnt;
	logic [7:0] exp_q [0:6];
	int err_count = 0;
	int comparisons = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	// reference clock runs throughout
	// offset keeps link edges clear of system clock edges
	initial begin
		#2.5;
		forever #80 clk_ref_in = ~clk_ref_in;
	end
	ckb_output_ctrl #(.LOCK_CYCLES(20)) i_ckb_output_ctrl (
		.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.clk_ref_in(clk_ref_in), .smb_clock_in(scl), .smb_data_in(sda),
		.smb_data_out(sdo), .smb_data_oe_n_out(oe_n),
		.power_down_n_in(pd_n), .output_halt_request_n_in(halt_n),
		.clock_output_true_out(t), .clock_output_true_oe_n_out(t_oe_n),
		.clock_output_complement_out(c),
		.clock_output_complement_oe_n_out(c_oe_n),
		.reduced_drive_out(rdd), .pll_enable_out(pll_en),
		.loop_bandwidth_select_out(bw), .pll_mode_select_out(pm));
	ckb_host_model i_ckb_host_model (.clk_in(clk_sys_in),
		.dev_oe_n_in(oe_n), .scl_out(scl), .sda_out(sda));
	task automatic end_of_test;
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic rw(input int n);
		repeat (n) @(posedge clk_ref_in);
		@(negedge clk_sys_in);
	endtask : rw
	task automatic put(input logic [7:0] idx, input logic [7:0] d);
		logic a;
		i_ckb_host_model.wr(8'hDC, idx, d, a);
		`CHK("ack", 1'b0, a)
		rw(12);
	endtask : put
	initial begin
		#900us;
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (16) @(negedge clk_sys_in);
		rw(4);
		reset_n_in = 1'b1;
		rw(4);
		exp_q = '{8'h07, 8'hFF, 8'h00, 8'h00, ckb_pkg::ID_VENDOR_REV,
			ckb_pkg::ID_DEVICE, 8'h07};
		i_ckb_host_model.rd(8'h00, 7, cnt);
		`CHK("count", 8'h07, cnt)
		`CHK("sda drive", 1'b0, sdo)
		for (int i = 0; i < 7; i++) begin
			`CHK("reset", exp_q[i], i_ckb_host_model.buf_q[i])
		end
		`CHK("bw", 1'b1, bw)
		`CHK("pll mode", 1'b1, pm)
		put(8'h03, 8'h3C);
		put(8'h04, 8'h00);
		put(8'h00, 8'h01);
		`CHK("bw", 1'b0, bw)
		`CHK("pll mode", 1'b0, pm)
		i_ckb_host_model.wr(8'hA0, 8'h03, 8'hFF, k);
		`CHK("bad addr", 1'b1, k)
		i_ckb_host_model.rd(8'h03, 5, cnt);
		exp_q = '{8'h3C, ckb_pkg::ID_VENDOR_REV, ckb_pkg::ID_DEVICE,
			8'h07, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) begin
			`CHK("stored", exp_q[i], i_ckb_host_model.buf_q[i])
		end
		`CHK("vendor", ckb_pkg::ID_VENDOR_REV, i_ckb_host_model.buf_q[1])
		put(8'h02, 8'h0F);
		halt_n = 1'b0;
		rw(12);
		`CHK("stop oe", 8'h0F, {t_oe_n[3:0], c_oe_n[3:0]})
		`CHK("stop low", 4'h0, c[3:0])
		s = t;
		rw(1);
		`CHK("halted", {~s[7:4], 4'hF}, t)
		halt_n = 1'b1;
		rw(3);
		`CHK("early", 4'hF, t[3:0])
		rw(16);
		s = t;
		rw(1);
		`CHK("resume", ~s, t)
		`CHK("together", {4{s[0]}}, s[3:0])
		`CHK("complement", ~t, c)
		put(8'h00, 8'h41);
		halt_n = 1'b0;
		rw(12);
		`CHK("stop z", 8'hFF, {t_oe_n[3:0], c_oe_n[3:0]})
		halt_n = 1'b1;
		rw(5);
		`CHK("drive hi", 8'h0F, {t_oe_n[3:0], t[3:0]})
		rw(16);
		put(8'h00, 8'h01);
		pd_n = 1'b0;
		rw(12);
		`CHK("park", 8'hFF, t)
		`CHK("park oe", 16'h00FF, {t_oe_n, c_oe_n})
		`CHK("reduced", 1'b1, rdd)
		`CHK("pll off", 1'b0, pll_en)
		pd_n = 1'b1;
		rw(20);
		`CHK("relock", 2'b10, {pll_en, rdd})
		put(8'h00, 8'h81);
		pd_n = 1'b0;
		rw(12);
		`CHK("park z", 16'hFFFF, {t_oe_n, c_oe_n})
		pd_n = 1'b1;
		rw(12);
		`CHK("wake", 8'h00, t_oe_n)
		rw(20);
		put(8'h01, 8'hFE);
		`CHK("off", 2'b11, {t_oe_n[0], c_oe_n[0]})
		put(8'h00, 8'h00);
		s = t;
		rw(2);
		`CHK("half rate", ~s[7:1], t[7:1])
		end_of_test();
	end
endmodule : clock_buffer_output_control_bench
`default_nettype wire
